/* hdl/nbx_core.sv */
// Purpose: Decode and execute branch, register and port instructions
// Assumes: Instruction words arrive on a valid/ready port; test and port pins are asynchronous
// Notes: Every instruction runs fetch, optional second fetch, then three execute slots
`timescale 1ns/1ps
module nbx_core
(
  input logic clk,
  input logic rst_n,
  input logic instr_valid,
  input logic [7:0] instr_word,
  output logic instr_ready,
  input logic test_pin,
  input logic [3:0] port_in,
  output logic [3:0] bus_data,
  output logic bus_oe,
  output logic exec_slot_two,
  output logic select_active,
  output logic port_write_active,
  output logic [nbx_pkg::PC_W-1:0] pc,
  output logic [3:0] acc,
  output logic carry
);
  import nbx_pkg::*;

  nbx_state_e state_reg, state_next;
  logic [7:0] op_reg, op_next;
  logic [7:0] imm_reg, imm_next;
  logic [PC_W-1:0] pc_reg, pc_next;
  logic [3:0] acc_reg, acc_next;
  logic carry_reg, carry_next;
  logic [3:0] bus_data_reg, bus_data_next;
  logic bus_oe_reg, bus_oe_next;
  logic test_meta, test_sync;
  logic [3:0] port_meta, port_sync;

  logic [7:0] dec_word;
  logic [3:0] opcode_nibble, operand_nibble;
  logic is_pair, two_word;
  logic [3:0] addr_a, addr_b, rd_a, rd_b, wd_a, wd_b;
  logic we_a, we_b;
  logic cond_hit, cond_jump_go;
  logic is_cond_jump, is_pair_load, is_select, is_inc_skip, is_add;
  logic is_swap, is_acc_imm, is_port_write, is_port_read;
  logic is_carry_inv, is_rot_left, is_rot_right;
  logic [4:0] sum;

  // Pins are asynchronous to clk
  always_ff @(posedge clk)
  begin
    if (!rst_n)
    begin
      test_meta <= 1'b1;
      test_sync <= 1'b1;
      port_meta <= 4'h0;
      port_sync <= 4'h0;
    end
    else
    begin
      test_meta <= test_pin;
      test_sync <= test_meta;
      port_meta <= port_in;
      port_sync <= port_meta;
    end
  end

  // Read address follows the incoming word so data are ready at X1
  assign dec_word = (state_reg == S_FETCH) ? instr_word : op_reg;
  assign opcode_nibble = op_reg[7:4];
  assign operand_nibble = op_reg[3:0];
  assign is_pair = dec_word[7:4] == OPC_PAIR_SEL;
  assign addr_a = is_pair ? {dec_word[3:1], 1'b0} : dec_word[3:0];
  assign addr_b = {dec_word[3:1], 1'b1};
  assign two_word = instr_word[7:4] == OPC_COND_JUMP || instr_word[7:4] == OPC_INC_SKIP
    || (instr_word[7:4] == OPC_PAIR_SEL && !instr_word[0]);

  assign is_cond_jump = opcode_nibble == OPC_COND_JUMP;
  assign is_pair_load = opcode_nibble == OPC_PAIR_SEL && !operand_nibble[0];
  assign is_select = opcode_nibble == OPC_PAIR_SEL && operand_nibble[0];
  assign is_inc_skip = opcode_nibble == OPC_INC_SKIP;
  assign is_add = opcode_nibble == OPC_REG_ADD;
  assign is_swap = opcode_nibble == OPC_REG_SWAP;
  assign is_acc_imm = opcode_nibble == OPC_ACC_IMM;
  assign is_port_write = op_reg == {OPC_IO_GROUP, OPN_RAM_PORT_WRITE};
  assign is_port_read = op_reg == {OPC_IO_GROUP, OPN_ROM_PORT_READ};
  assign is_carry_inv = op_reg == {OPC_ACC_GROUP, OPN_CARRY_INVERT};
  assign is_rot_left = op_reg == {OPC_ACC_GROUP, OPN_ROTATE_LEFT};
  assign is_rot_right = op_reg == {OPC_ACC_GROUP, OPN_ROTATE_RIGHT};

  // Any enabled condition may hit; the invert bit flips the result
  assign cond_hit = (operand_nibble[COND_ACC_BIT] && acc_reg == 4'h0)
    || (operand_nibble[COND_CY_BIT] && carry_reg)
    || (operand_nibble[COND_TEST_BIT] && !test_sync);
  assign cond_jump_go = cond_hit ^ operand_nibble[COND_INV_BIT];

  assign sum = {1'b0, acc_reg} + {1'b0, rd_a};

  // Register writes happen only in X3, once the old contents were read
  always_comb
  begin
    we_a = 1'b0;
    we_b = 1'b0;
    wd_a = rd_a;
    wd_b = rd_b;
    if (state_reg == S_X3)
    begin
      if (is_pair_load)
      begin
        we_a = 1'b1;
        we_b = 1'b1;
        wd_a = imm_reg[7:4];
        wd_b = imm_reg[3:0];
      end
      else if (is_swap)
      begin
        we_a = 1'b1;
        wd_a = acc_reg;
      end
      else if (is_inc_skip)
      begin
        we_a = 1'b1;
        wd_a = rd_a + 4'h1;
      end
    end
  end

  nbx_regfile u_regfile (
    .clk(clk),
    .rst_n(rst_n),
    .addr_a(addr_a),
    .addr_b(addr_b),
    .we_a(we_a),
    .wd_a(wd_a),
    .we_b(we_b),
    .wd_b(wd_b),
    .rd_a(rd_a),
    .rd_b(rd_b)
  );

  always_comb
  begin
    state_next = state_reg;
    op_next = op_reg;
    imm_next = imm_reg;
    pc_next = pc_reg;
    acc_next = acc_reg;
    carry_next = carry_reg;
    bus_data_next = bus_data_reg;
    bus_oe_next = bus_oe_reg;
    unique case (state_reg)
      S_FETCH:
      begin
        if (instr_valid)
        begin
          op_next = instr_word;
          pc_next = pc_reg + 12'h001;
          state_next = two_word ? S_FETCH2 : S_X1;
        end
      end
      S_FETCH2:
      begin
        if (instr_valid)
        begin
          imm_next = instr_word;
          pc_next = pc_reg + 12'h001;
          state_next = S_X1;
        end
      end
      S_X1:
      begin
        state_next = S_MID;
        if (is_select)
        begin
          bus_data_next = rd_a;
          bus_oe_next = 1'b1;
        end
        else if (is_port_write)
        begin
          bus_data_next = acc_reg;
          bus_oe_next = 1'b1;
        end
      end
      S_MID:
      begin
        state_next = S_X3;
        if (is_select)
          bus_data_next = rd_b;
        else if (is_port_write)
          bus_data_next = {CARRY_SLOT_FILL, carry_reg};
      end
      S_X3:
      begin
        state_next = S_FETCH;
        bus_oe_next = 1'b0;
        if (is_cond_jump && cond_jump_go)
          pc_next = {pc_reg[PC_W-1:PAGE_W], imm_reg};
        else if (is_inc_skip && rd_a != 4'hf)
          pc_next = {pc_reg[PC_W-1:PAGE_W], imm_reg};
        else if (is_add)
          {carry_next, acc_next} = sum;
        else if (is_swap)
          acc_next = rd_a;
        else if (is_acc_imm)
          acc_next = operand_nibble;
        else if (is_port_read)
          acc_next = port_sync;
        else if (is_carry_inv)
          carry_next = !carry_reg;
        else if (is_rot_left)
          {carry_next, acc_next} = {acc_reg, carry_reg};
        else if (is_rot_right)
          {acc_next, carry_next} = {carry_reg, acc_reg};
      end
    endcase
  end

  always_ff @(posedge clk)
  begin
    if (!rst_n)
    begin
      state_reg <= S_FETCH;
      op_reg <= WORD_RST;
      imm_reg <= WORD_RST;
      pc_reg <= PC_RST;
      acc_reg <= ACC_RST;
      carry_reg <= CARRY_RST;
      bus_data_reg <= 4'h0;
      bus_oe_reg <= 1'b0;
    end
    else
    begin
      state_reg <= state_next;
      op_reg <= op_next;
      imm_reg <= imm_next;
      pc_reg <= pc_next;
      acc_reg <= acc_next;
      carry_reg <= carry_next;
      bus_data_reg <= bus_data_next;
      bus_oe_reg <= bus_oe_next;
    end
  end

  assign instr_ready = state_reg == S_FETCH || state_reg == S_FETCH2;
  assign exec_slot_two = state_reg == S_MID;
  // Strobes cover both bus slots so partners can latch either nibble
  assign select_active = is_select && (state_reg == S_MID || state_reg == S_X3);
  assign port_write_active = is_port_write && (state_reg == S_MID || state_reg == S_X3);
  assign bus_data = bus_data_reg;
  assign bus_oe = bus_oe_reg;
  assign pc = pc_reg;
  assign acc = acc_reg;
  assign carry = carry_reg;

  default clocking cb @(posedge clk); endclocking
  default disable iff (!rst_n);

  a_two_word_fetch: assert property (
    state_reg == S_FETCH && instr_valid && instr_word[7:4] == OPC_COND_JUMP
    |=> state_reg == S_FETCH2)
    else $error("conditional jump not fetched as two words");

  a_jump_on_low: assert property (
    state_reg == S_X3 && is_cond_jump && operand_nibble == 4'h1 && !test_sync
    |=> pc_reg == {$past(pc_reg[11:8]), $past(imm_reg)})
    else $error("jump on low test not taken");

  a_jump_not_met: assert property (
    state_reg == S_X3 && is_cond_jump && !cond_jump_go |=> $stable(pc_reg))
    else $error("untaken jump changed program counter");

  a_jump_inverted: assert property (
    state_reg == S_X3 && is_cond_jump && operand_nibble == 4'h9
    |=> (pc_reg[7:0] == $past(imm_reg)) == $past(test_sync))
    else $error("inverted jump wrong sense");

  a_select_nibbles: assert property (
    state_reg == S_X1 && is_select
    |=> bus_oe && select_active && bus_data == $past(rd_a) ##1 bus_data == $past(rd_b))
    else $error("chip select nibbles wrong");

  a_port_read: assert property (
    state_reg == S_X3 && is_port_read |=> acc_reg == $past(port_sync))
    else $error("port read value wrong");

  a_imm_load: assert property (
    state_reg == S_X3 && is_acc_imm |=> acc_reg == $past(op_reg[3:0]))
    else $error("immediate load wrong");

  a_swap_both: assert property (
    state_reg == S_X3 && is_swap |-> we_a && wd_a == acc_reg ##1 acc_reg == $past(rd_a))
    else $error("swap incomplete");

  a_add_carry: assert property (
    state_reg == S_X3 && is_add
    |=> {carry_reg, acc_reg} == {1'b0, $past(acc_reg)} + {1'b0, $past(rd_a)})
    else $error("add result or carry wrong");

  a_rotate_left: assert property (
    state_reg == S_X3 && is_rot_left
    |=> {carry_reg, acc_reg} == {$past(acc_reg), $past(carry_reg)})
    else $error("rotate left wrong");

  a_write_slots: assert property (
    state_reg == S_X1 && is_port_write
    |=> exec_slot_two && bus_oe && bus_data == $past(acc_reg)
    ##1 bus_oe && bus_data == {3'h7, carry_reg})
    else $error("port write slots wrong");

  a_pair_load: assert property (
    state_reg == S_X3 && is_pair_load |-> we_a && we_b && {wd_a, wd_b} == imm_reg)
    else $error("pair load wrong");

  a_loop_jump: assert property (
    state_reg == S_X3 && is_inc_skip
    |=> pc_reg == ($past(rd_a) == 4'hf ? $past(pc_reg)
      : {$past(pc_reg[11:8]), $past(imm_reg)}))
    else $error("increment-and-skip target wrong");

  a_loop_keeps_acc: assert property (
    state_reg == S_X1 && is_inc_skip |=> $stable(acc_reg) [*3])
    else $error("increment-and-skip altered accumulator");

  c_jump_taken: cover property (state_reg == S_X3 && is_cond_jump && cond_jump_go);
  c_loop_back: cover property (state_reg == S_X3 && is_inc_skip && rd_a != 4'hf);
  c_loop_exit: cover property (state_reg == S_X3 && is_inc_skip && rd_a == 4'hf);
  c_port_write: cover property (state_reg == S_X3 && is_port_write);
endmodule

/* hdl/nbx_pkg.sv */
// Purpose: Shared constants for the nibble CPU branch and I/O executor
// Assumes: 4-bit data path, 12-bit program counter, 8-bit instruction words
// Notes: Opcode values are upper-nibble codes unless marked as lower nibbles
package nbx_pkg;

  localparam int PC_W = 12;
  localparam int PAGE_W = 8;

  // Upper-nibble opcodes
  localparam logic [3:0] OPC_COND_JUMP = 4'h1;
  localparam logic [3:0] OPC_PAIR_SEL = 4'h2;
  localparam logic [3:0] OPC_INC_SKIP = 4'h7;
  localparam logic [3:0] OPC_REG_ADD = 4'h8;
  localparam logic [3:0] OPC_REG_SWAP = 4'hb;
  localparam logic [3:0] OPC_ACC_IMM = 4'hd;
  localparam logic [3:0] OPC_IO_GROUP = 4'he;
  localparam logic [3:0] OPC_ACC_GROUP = 4'hf;

  // Lower nibble within the I/O and accumulator groups
  localparam logic [3:0] OPN_RAM_PORT_WRITE = 4'h1;
  localparam logic [3:0] OPN_ROM_PORT_READ = 4'ha;
  localparam logic [3:0] OPN_CARRY_INVERT = 4'h3;
  localparam logic [3:0] OPN_ROTATE_LEFT = 4'h5;
  localparam logic [3:0] OPN_ROTATE_RIGHT = 4'h6;

  // Condition field bit positions
  localparam int COND_INV_BIT = 3;
  localparam int COND_ACC_BIT = 2;
  localparam int COND_CY_BIT = 1;
  localparam int COND_TEST_BIT = 0;

  // Fill on upper bus bits while carry is shown at the third slot
  localparam logic [2:0] CARRY_SLOT_FILL = 3'h7;

  // Reset values
  localparam logic [PC_W-1:0] PC_RST = 12'h000;
  localparam logic [3:0] ACC_RST = 4'h0;
  localparam logic CARRY_RST = 1'b0;
  localparam logic [3:0] REG_RST = 4'h0;
  localparam logic [7:0] WORD_RST = 8'h00;

  typedef enum logic [2:0] {
    S_FETCH,
    S_FETCH2,
    S_X1,
    S_MID,
    S_X3
  } nbx_state_e;

endpackage

/* hdl/nbx_regfile.sv */
// Purpose: Sixteen 4-bit index registers with two registered read ports
// Assumes: Port A and port B never write the same entry in one cycle
// Notes: Read data appear one edge after the address
`timescale 1ns/1ps
module nbx_regfile
  import nbx_pkg::*;
(
  input logic clk,
  input logic rst_n,
  input logic [3:0] addr_a,
  input logic [3:0] addr_b,
  input logic we_a,
  input logic [3:0] wd_a,
  input logic we_b,
  input logic [3:0] wd_b,
  output logic [3:0] rd_a,
  output logic [3:0] rd_b
);
  logic [3:0] mem [16];

  for (genvar i = 0; i < 16; i++)
  begin : g_entry
    always_ff @(posedge clk)
    begin
      if (!rst_n)
        mem[i] <= REG_RST;
      else if (we_a && addr_a == 4'(i))
        mem[i] <= wd_a;
      else if (we_b && addr_b == 4'(i))
        mem[i] <= wd_b;
    end
  end

  always_ff @(posedge clk)
  begin
    if (!rst_n)
    begin
      rd_a <= REG_RST;
      rd_b <= REG_RST;
    end
    else
    begin
      rd_a <= mem[addr_a];
      rd_b <= mem[addr_b];
    end
  end
endmodule

/* verif/nbx_port_model.sv */
// Purpose: Behavioural ROM and RAM port chips on the shared nibble bus
// Assumes: Selection nibbles and port writes arrive as the core drives them
// Notes: Only ROM chip two drives its port pins, with a fixed pattern
`timescale 1ns/1ps
module nbx_port_model
(
  input logic clk,
  input logic rst_n,
  input logic [3:0] bus_data,
  input logic bus_oe,
  input logic exec_slot_two,
  input logic select_active,
  input logic port_write_active,
  output logic [3:0] port_in,
  output logic [3:0] sel_hi,
  output logic [3:0] sel_lo,
  output logic [3:0] wr_tail,
  output logic [15:0] ram_ports
);
  localparam logic [3:0] ROM_NUM = 4'h2;
  localparam logic [3:0] ROM_PINS = 4'h4;

  // Each ROM chip answers only when its own number was sent
  assign port_in = (sel_hi == ROM_NUM) ? ROM_PINS : 4'h0;

  always_ff @(posedge clk)
  begin
    if (!rst_n)
    begin
      sel_hi <= 4'h0;
      sel_lo <= 4'h0;
      wr_tail <= 4'h0;
      ram_ports <= 16'h0000;
    end
    else
    begin
      if (bus_oe && select_active && exec_slot_two)
        sel_hi <= bus_data;
      else if (bus_oe && select_active)
        sel_lo <= bus_data;
      // Top two bits of the selection pick the RAM chip
      if (bus_oe && port_write_active && exec_slot_two)
        ram_ports[{sel_hi[3:2], 2'b00} +: 4] <= bus_data;
      else if (bus_oe && port_write_active)
        wr_tail <= bus_data;
    end
  end
endmodule

/* verif/nibble_cpu_branch_io_exec_tb_top.sv */
// Purpose: Self-checking bench for the nibble executor core
// Assumes: Words are offered at the falling edge and held until taken
// Notes: Index registers are read back through a pair of swaps
`timescale 1ns/1ps
module nibble_cpu_branch_io_exec_tb_top;
  import nbx_pkg::*;
  logic clk = 1'b0;
  logic rst_n = 1'b0;
  logic instr_valid = 1'b0;
  logic [7:0] instr_word = 8'h00;
  logic test_pin = 1'b1;
  logic instr_ready, bus_oe, exec_slot_two, select_active, port_write_active, carry;
  logic [3:0] port_in, bus_data, acc, sel_hi, sel_lo, wr_tail;
  logic [15:0] ram_ports;
  logic [PC_W-1:0] pc;
  logic [PC_W-1:0] exp_pc = 12'h000;
  logic [7:0] cj_w [5] = '{8'h11, 8'h11, 8'h19, 8'h19, 8'h11};
  logic [7:0] cj_g [5] = '{8'h20, 8'h30, 8'h40, 8'h50, 8'hfe};
  logic cj_t [5] = '{1'b0, 1'b1, 1'b1, 1'b0, 1'b0};
  logic cj_y [5] = '{1'b1, 1'b0, 1'b1, 1'b0, 1'b1};
  logic [7:0] rot_w [7] = '{8'hf3, 8'hf5, 8'hf3, 8'hf6, 8'hf5, 8'hf3, 8'hf6};
  logic [3:0] rot_a [7] = '{4'h0, 4'h0, 4'h0, 4'h8, 4'h0, 4'h0, 4'h0};
  logic rot_c [7] = '{1'b0, 1'b0, 1'b1, 1'b0, 1'b1, 1'b0, 1'b0};
  int err_count = 0;
  int num_checks = 0;

  always #2 clk = ~clk;

  nbx_core dut (.clk(clk), .rst_n(rst_n), .instr_valid(instr_valid),
    .instr_word(instr_word), .instr_ready(instr_ready), .test_pin(test_pin),
    .port_in(port_in), .bus_data(bus_data), .bus_oe(bus_oe),
    .exec_slot_two(exec_slot_two), .select_active(select_active),
    .port_write_active(port_write_active), .pc(pc), .acc(acc), .carry(carry));

  nbx_port_model partner (.clk(clk), .rst_n(rst_n), .bus_data(bus_data), .bus_oe(bus_oe),
    .exec_slot_two(exec_slot_two), .select_active(select_active),
    .port_write_active(port_write_active), .port_in(port_in), .sel_hi(sel_hi),
    .sel_lo(sel_lo), .wr_tail(wr_tail), .ram_ports(ram_ports));

  task automatic results();
    $display("checks %0d mismatches %0d", num_checks, err_count);
    if (err_count == 0 && num_checks > 0)
      $display("Result: passed");
    else
      $display("Result: failed");
    $finish;
  endtask

  task automatic chk(input string name, input logic [11:0] e, input logic [11:0] g);
    num_checks++;
    if (g !== e)
    begin
      err_count++;
      $display("mismatch %s expected %h seen %h", name, e, g);
    end
  endtask

  // Bounded wait; a hang ends the run with a failure
  task automatic wait_ready();
    int n;
    n = 0;
    while (instr_ready !== 1'b1 && n < 50)
    begin
      @(negedge clk);
      n++;
    end
    if (instr_ready !== 1'b1)
    begin
      err_count++;
      results();
    end
  endtask

  // Valid stays up between the two words of one instruction
  task automatic send(input logic [7:0] w);
    wait_ready();
    instr_valid = 1'b1;
    instr_word = w;
    @(negedge clk);
    exp_pc = exp_pc + 12'h001;
  endtask

  task automatic op1(input logic [7:0] w);
    send(w);
    instr_valid = 1'b0;
    wait_ready();
  endtask

  task automatic op2(input logic [7:0] w1, input logic [7:0] w2);
    send(w1);
    send(w2);
    instr_valid = 1'b0;
    wait_ready();
  endtask

  task automatic chk_ac(input logic [3:0] ea, input logic ec);
    chk("acc", {8'h00, ea}, {8'h00, acc});
    chk("carry", {11'h000, ec}, {11'h000, carry});
    chk("pc", exp_pc, pc);
  endtask

  task automatic rd_reg(input logic [3:0] r, input logic [3:0] e);
    op1({OPC_REG_SWAP, r});
    chk("reg", {8'h00, e}, {8'h00, acc});
    op1({OPC_REG_SWAP, r});
  endtask

  task automatic jump(input logic [7:0] w1, input logic [7:0] w2, input logic taken);
    op2(w1, w2);
    if (taken)
      exp_pc = {exp_pc[11:8], w2};
    chk("pc", exp_pc, pc);
  endtask

  initial
  begin
    repeat (20) @(negedge clk);
    rst_n = 1'b1;
    chk_ac(ACC_RST, CARRY_RST);
    chk("bus_oe", 12'h000, {11'h000, bus_oe});
    op1(8'hd8);
    chk_ac(4'h8, 1'b0);
    op1(8'hbf);
    chk_ac(4'h0, 1'b0);
    rd_reg(4'hf, 4'h8);
    op1(8'hd6);
    op1(8'hbe);
    op2(8'h20, 8'hc5);
    rd_reg(4'h0, 4'hc);
    rd_reg(4'h1, 4'h5);
    op1(8'h21);
    chk("sel_hi", 12'h00c, {8'h00, sel_hi});
    chk("sel_lo", 12'h005, {8'h00, sel_lo});
    op1(8'hd0);
    op1(8'h8f);
    chk_ac(4'h8, 1'b0);
    op1(8'he1);
    chk("ram3", 12'h008, {8'h00, ram_ports[15:12]});
    chk("wr_tail", 12'h00e, {8'h00, wr_tail});
    chk("bus_oe", 12'h000, {11'h000, bus_oe});
    op1(8'h8f);
    chk_ac(4'h0, 1'b1);
    op1(8'he1);
    chk("ram3", 12'h000, {8'h00, ram_ports[15:12]});
    chk("wr_tail", 12'h00f, {8'h00, wr_tail});
    for (int i = 0; i < 7; i++)
    begin
      op1(rot_w[i]);
      chk_ac(rot_a[i], rot_c[i]);
    end
    op2(8'h20, 8'h20);
    op1(8'h21);
    chk("sel_hi", 12'h002, {8'h00, sel_hi});
    chk("sel_lo", 12'h000, {8'h00, sel_lo});
    op1(8'hea);
    chk_ac(4'h4, 1'b0);
    op1(8'h8f);
    op1(8'h8f);
    jump(8'h12, 8'h60, 1'b1);
    op1(8'hf3);
    jump(8'h12, 8'h70, 1'b0);
    for (int i = 0; i < 5; i++)
    begin
      test_pin = cj_t[i];
      repeat (3) @(negedge clk);
      jump(cj_w[i], cj_g[i], cj_y[i]);
    end
    // Loop instruction straddles the page boundary from here
    op1(8'hd5);
    jump(8'h7e, 8'h40, 1'b1);
    chk_ac(4'h5, 1'b0);
    rd_reg(4'he, 4'h7);
    op1(8'hdf);
    op1(8'hbe);
    jump(8'h7e, 8'h40, 1'b0);
    chk_ac(4'h7, 1'b0);
    rd_reg(4'he, 4'h0);
    results();
  end
endmodule
